// ### pcb_config_header.sv
// Purpose: Status, identity, latency, base address and bus number slice
//          of the bridge configuration header
// Assumes: Error events are same-clock pulses; grant arrives from a pin
// Notes:   Byte-wide register port, read data one cycle after strobe
//
// What this block does
// - Primary bit 15 parity error, write-one clears
// - Primary bit 13 master abort, write-one clears
// - Primary bit 12 target abort received, sticky
// - Card bus bit 12 target abort received
// - Bit 11 both: target abort signalled
// - Bit 14 both: system error reported
// - Bits 10:9 read 01b, never written
// - Primary bit 8 data parity, write-one clears
// - Card bus bit 8 data parity error
// - Grant gone: stop after latency expiry
// - Latency 0 off, 1..8 give 8..64
// - Header type reads 82h, read-only
// - Class code 06h/07h/00h, read-only
// - Base address bits 31:12 writable only
// - Base address low indicators read zero
// - Bus match claims and issues Type 0
// - Subordinate range forwards Type 1 cycles
// - Revision register returns fixed level
// - Error-report enable gates system error
`timescale 1ns/1ps
`include "pcb_consts.svh"

module pcb_config_header
	import pcb_pkg::*;
#(
	parameter logic [7:0] SILICON_REVISION = 8'h5A  // Arbitrary value
) (
	// Clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_sys_rst,
	// Register port
	input  wire pcb_bus_req_s i_bus,
	output logic [7:0]        o_rd_data,
	// Error events
	input  wire pcb_evt_s     i_evt,
	// Primary master tenure
	input  wire logic         i_master_active,
	input  wire logic         i_gnt_n,
	output logic              o_lat_stop,
	output logic              o_serr_report,
	// Type 1 configuration decode
	input  wire logic         i_cfg_t1_valid,
	input  wire logic [7:0]   i_cfg_t1_bus,
	output pcb_route_s        o_route,
	// Stored primary bus number for the forwarding logic
	output logic [7:0]        o_primary_bus_number
);

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [15:0] pri_sts;    // Primary sticky flags
		logic [15:0] sec_sts;    // Card bus sticky flags
		logic        serr_en;    // Error-report enable
		logic [7:0]  lat;        // Primary master latency setting
		logic [19:0] bar;        // Socket window base, bits 31:12
		logic [7:0]  pbus;       // Primary bus number
		logic [7:0]  sbus;       // Card bus number
		logic [7:0]  subus;      // Highest downstream bus number
		logic [2:0]  gsync;      // Grant synchroniser, [0] first
		logic        gnt_n_f;    // Agreed grant level
		pcb_lat_e    lat_st;     // Timer machine
		logic [6:0]  lat_cnt;    // Clocks left before expiry
		logic        lat_stop;   // Stop request out
		logic        serr_out;   // System error pulse out
		logic [7:0]  rd_data;    // Read data out
		pcb_route_s  route;      // Routing answer out
	} pcb_state_s;

	localparam pcb_state_s PCB_RST = '{
		pri_sts:  `PCB_STS_RESET,
		sec_sts:  `PCB_STS_RESET,
		serr_en:  1'b0,
		lat:      `PCB_LAT_RESET,
		bar:      20'h00000,
		pbus:     `PCB_BUSN_RESET,
		sbus:     `PCB_BUSN_RESET,
		subus:    `PCB_BUSN_RESET,
		gsync:    3'h7,
		gnt_n_f:  1'b1,
		lat_st:   PCB_LAT_IDLE,
		lat_cnt:  7'h00,
		lat_stop: 1'b0,
		serr_out: 1'b0,
		rd_data:  8'h00,
		route:    3'h0
	};

	pcb_state_s st_r;            // Registered state
	pcb_state_s st_nxt;          // Next state

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------
	// Write strobe aimed at one byte offset
	function automatic logic wr_hit(input pcb_bus_req_s b, input logic [7:0] off);
		wr_hit = b.wr && (b.addr == off);
	endfunction : wr_hit

	// Status byte view: sticky flags plus fixed timing code
	function automatic logic [15:0] sts_view(input logic [15:0] s);
		sts_view = (s & `PCB_STS_W1C_MASK) | `PCB_STS_DEVSEL_MED;
	endfunction : sts_view

	// Read multiplexer over byte offsets
	function automatic logic [7:0] rd_byte(input pcb_state_s s, input logic [7:0] a);
		logic [15:0] pv;
		logic [15:0] sv;
		pv = sts_view(s.pri_sts);
		sv = sts_view(s.sec_sts);
		case (a)
			`PCB_OFF_ERR_CTRL:   rd_byte = {7'h00, s.serr_en};
			`PCB_OFF_PRI_STS_LO: rd_byte = pv[7:0];
			`PCB_OFF_PRI_STS_HI: rd_byte = pv[15:8];
			`PCB_OFF_REVISION:   rd_byte = SILICON_REVISION;
			`PCB_OFF_CLASS_PIF:  rd_byte = `PCB_CLASS_PIF;
			`PCB_OFF_CLASS_SUB:  rd_byte = `PCB_CLASS_SUB;
			`PCB_OFF_CLASS_BASE: rd_byte = `PCB_CLASS_BASE;
			`PCB_OFF_LATENCY:    rd_byte = s.lat;
			`PCB_OFF_HDR_TYPE:   rd_byte = `PCB_HDR_TYPE;
			`PCB_OFF_BAR_B0:     rd_byte = 8'h00;
			`PCB_OFF_BAR_B1:     rd_byte = {s.bar[3:0], 4'h0};
			`PCB_OFF_BAR_B2:     rd_byte = s.bar[11:4];
			`PCB_OFF_BAR_B3:     rd_byte = s.bar[19:12];
			`PCB_OFF_SEC_STS_LO: rd_byte = sv[7:0];
			`PCB_OFF_SEC_STS_HI: rd_byte = sv[15:8];
			`PCB_OFF_PRI_BUSN:   rd_byte = s.pbus;
			`PCB_OFF_SEC_BUSN:   rd_byte = s.sbus;
			`PCB_OFF_SUB_BUSN:   rd_byte = s.subus;
			// Unmapped offsets read as zero
			default:             rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	// --------------------------------------------------------------
	// Combinational helpers
	// --------------------------------------------------------------
	logic        serr_ok;        // System error allowed out
	logic [15:0] pri_set;        // Primary flags to set now
	logic [15:0] sec_set;        // Card bus flags to set now
	logic [15:0] pri_clr;        // Primary flags software clears
	logic [15:0] sec_clr;        // Card bus flags software clears
	logic        lat_en;         // Setting selects a running timer

	// Event to flag mapping and write-one-to-clear masks
	always_comb begin
		serr_ok = i_evt.sys_err && st_r.serr_en;
		pri_set = 16'h0000;
		pri_set[`PCB_STS_PERR]       = i_evt.pri_perr;
		pri_set[`PCB_STS_SERR]       = serr_ok;
		pri_set[`PCB_STS_MABORT]     = i_evt.pri_mabort;
		pri_set[`PCB_STS_TABORT_RX]  = i_evt.pri_tabort_rx;
		pri_set[`PCB_STS_TABORT_SIG] = i_evt.tabort_sig;
		pri_set[`PCB_STS_DPERR]      = i_evt.pri_dperr;
		sec_set = 16'h0000;
		sec_set[`PCB_STS_PERR]       = i_evt.sec_perr;
		sec_set[`PCB_STS_SERR]       = serr_ok;
		sec_set[`PCB_STS_MABORT]     = i_evt.sec_mabort;
		sec_set[`PCB_STS_TABORT_RX]  = i_evt.sec_tabort_rx;
		sec_set[`PCB_STS_TABORT_SIG] = i_evt.tabort_sig;
		sec_set[`PCB_STS_DPERR]      = i_evt.sec_dperr;
		// Only the high byte holds clearable flags; low byte writes vanish
		pri_clr = wr_hit(i_bus, `PCB_OFF_PRI_STS_HI) ?
		          ({i_bus.wdata, 8'h00} & `PCB_STS_W1C_MASK) : 16'h0000;
		sec_clr = wr_hit(i_bus, `PCB_OFF_SEC_STS_HI) ?
		          ({i_bus.wdata, 8'h00} & `PCB_STS_W1C_MASK) : 16'h0000;
		// Reserved settings above 8 behave as a stopped timer
		lat_en = (st_r.lat != 8'h00) && (st_r.lat <= `PCB_LAT_MAX_SETTING);
	end

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;

		// Sticky flags: an event in the clearing cycle survives
		st_nxt.pri_sts = (st_r.pri_sts & ~pri_clr) | pri_set;
		st_nxt.sec_sts = (st_r.sec_sts & ~sec_clr) | sec_set;

		// Plain storage registers
		if (wr_hit(i_bus, `PCB_OFF_ERR_CTRL)) begin
			st_nxt.serr_en = i_bus.wdata[0];
		end
		if (wr_hit(i_bus, `PCB_OFF_LATENCY)) begin
			st_nxt.lat = i_bus.wdata;
		end
		// Base address: only bits 31:12 take writes
		if (wr_hit(i_bus, `PCB_OFF_BAR_B1)) begin
			st_nxt.bar[3:0] = i_bus.wdata[7:4];
		end
		if (wr_hit(i_bus, `PCB_OFF_BAR_B2)) begin
			st_nxt.bar[11:4] = i_bus.wdata;
		end
		if (wr_hit(i_bus, `PCB_OFF_BAR_B3)) begin
			st_nxt.bar[19:12] = i_bus.wdata;
		end
		// Bus numbers, written by configuration software
		if (wr_hit(i_bus, `PCB_OFF_PRI_BUSN)) begin
			st_nxt.pbus = i_bus.wdata;
		end
		if (wr_hit(i_bus, `PCB_OFF_SEC_BUSN)) begin
			st_nxt.sbus = i_bus.wdata;
		end
		if (wr_hit(i_bus, `PCB_OFF_SUB_BUSN)) begin
			st_nxt.subus = i_bus.wdata;
		end

		// Read data stands only in the cycle after the strobe
		st_nxt.rd_data = i_bus.rd ? rd_byte(st_r, i_bus.addr) : 8'h00;

		// Grant pin: accept a change once stages two and three agree
		st_nxt.gsync = {st_r.gsync[1:0], i_gnt_n};
		if (st_r.gsync[1] == st_r.gsync[2]) begin
			st_nxt.gnt_n_f = st_r.gsync[2];
		end

		// Latency timer, restarted at each master tenure
		case (st_r.lat_st)
			PCB_LAT_IDLE: begin
				// Load at tenure start; a zero setting never runs
				if (i_master_active && lat_en) begin
					st_nxt.lat_cnt = {st_r.lat[3:0], 3'h0};
					st_nxt.lat_st  = PCB_LAT_RUN;
				end
			end
			PCB_LAT_RUN: begin
				if (!i_master_active) begin
					st_nxt.lat_st = PCB_LAT_IDLE;
				end else if (st_r.lat_cnt == 7'h01) begin
					st_nxt.lat_cnt = 7'h00;
					st_nxt.lat_st  = PCB_LAT_DONE;
				end else begin
					st_nxt.lat_cnt = st_r.lat_cnt - 7'h01;
				end
			end
			PCB_LAT_DONE: begin
				// Held expired until the tenure ends
				if (!i_master_active) begin
					st_nxt.lat_st = PCB_LAT_IDLE;
				end
			end
			default: begin
				st_nxt.lat_st = PCB_LAT_IDLE;
			end
		endcase
		// Stop only once the agreed grant is gone and the timer has run out;
		// the registered grant level keeps the stop one edge behind the filter
		st_nxt.lat_stop = i_master_active && st_r.gnt_n_f &&
		                  (st_r.lat_st == PCB_LAT_DONE);

		// System error pulse, suppressed while reporting is off
		st_nxt.serr_out = serr_ok;

		// Type 1 decode: exact match claims, range above forwards
		st_nxt.route.valid      = i_cfg_t1_valid;
		st_nxt.route.to_type0   = i_cfg_t1_valid &&
		                          (i_cfg_t1_bus == st_r.sbus);
		st_nxt.route.pass_type1 = i_cfg_t1_valid &&
		                          (i_cfg_t1_bus > st_r.sbus) &&
		                          (i_cfg_t1_bus <= st_r.subus);
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_r <= PCB_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign o_rd_data            = st_r.rd_data;
	assign o_lat_stop           = st_r.lat_stop;
	assign o_serr_report        = st_r.serr_out;
	assign o_route              = st_r.route;
	assign o_primary_bus_number = st_r.pbus;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	perr_set_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_evt.pri_perr |=> st_r.pri_sts[`PCB_STS_PERR])
		else $error("primary parity flag not set");

	mabort_clear_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		wr_hit(i_bus, `PCB_OFF_PRI_STS_HI) && i_bus.wdata[5] && !i_evt.pri_mabort
		|=> !st_r.pri_sts[`PCB_STS_MABORT])
		else $error("master abort flag not cleared");

	tabort_hold_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		st_r.pri_sts[`PCB_STS_TABORT_RX] && !pri_clr[`PCB_STS_TABORT_RX]
		|=> st_r.pri_sts[`PCB_STS_TABORT_RX])
		else $error("target abort flag lost");

	sec_tabort_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_evt.sec_tabort_rx |=> st_r.sec_sts[`PCB_STS_TABORT_RX])
		else $error("card bus target abort flag not set");

	tabort_both_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_evt.tabort_sig |=> st_r.pri_sts[11] && st_r.sec_sts[11])
		else $error("signalled target abort not in both");

	serr_gate_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		!st_r.serr_en && !st_r.pri_sts[`PCB_STS_SERR]
		|=> !st_r.pri_sts[`PCB_STS_SERR] && !o_serr_report)
		else $error("system error reported while disabled");

	devsel_read_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_bus.rd && (i_bus.addr == `PCB_OFF_SEC_STS_HI) |=> o_rd_data[2:1] == 2'b01)
		else $error("timing code not 01b");

	hdr_read_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_bus.rd && (i_bus.addr == `PCB_OFF_HDR_TYPE) |=> o_rd_data == 8'h82)
		else $error("header type wrong");

	bar_low_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_bus.rd && (i_bus.addr == `PCB_OFF_BAR_B0) |=> o_rd_data == 8'h00)
		else $error("base address low bits not zero");

	cfg_claim_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_cfg_t1_valid && (i_cfg_t1_bus == st_r.sbus)
		|=> o_route.to_type0 && !o_route.pass_type1)
		else $error("matching bus not claimed");

	lat_off_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		((st_r.lat == 8'h00) || (st_r.lat > 8'h08)) && (st_r.lat_st == PCB_LAT_IDLE)
		|=> (st_r.lat_st == PCB_LAT_IDLE) && !o_lat_stop)
		else $error("stopped timer started or forced a stop");

	lat_run_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st_r.lat_st == PCB_LAT_RUN) && (st_r.lat_cnt == 7'h01) && i_master_active
		##1 i_master_active && st_r.gnt_n_f |=> o_lat_stop)
		else $error("no stop after expiry with grant gone");

	// Range above the card bus, up to the subordinate, passes on unchanged
	route_fwd_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_cfg_t1_valid && (i_cfg_t1_bus > st_r.sbus) && (i_cfg_t1_bus <= st_r.subus)
		|=> o_route.pass_type1 && !o_route.to_type0)
		else $error("bus in range not forwarded");

	class_read_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_bus.rd && (i_bus.addr == `PCB_OFF_CLASS_BASE) |=> o_rd_data == 8'h06)
		else $error("base class wrong");

	pri_dperr_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_evt.pri_dperr |=> st_r.pri_sts[`PCB_STS_DPERR])
		else $error("primary data parity flag not set");

	sts_low_a: assert property (
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_bus.rd && (i_bus.addr == `PCB_OFF_PRI_STS_LO) |=> o_rd_data == 8'h00)
		else $error("reserved status bits not zero");

endmodule : pcb_config_header

// ### pcb_config_header_tb.sv
// Purpose: Self-checking bench for the config header slice
// Assumes: Host model speaks the byte port; events and grant driven here
// Notes:   Expected values come from tables built from the register map
`timescale 1ns/1ps

module pcb_config_header_tb;
	import pcb_pkg::*;

	// --------------------------------------------------------------
	// Signals and tables
	// --------------------------------------------------------------
	localparam logic [7:0] REV = 8'h5A;   // Arbitrary revision value
	logic         i_clk_sys;              // 100 MHz clock
	logic         i_sys_rst;              // Synchronous reset
	pcb_bus_req_s i_bus;                  // From host model
	logic [7:0]   o_rd_data;              // Read byte
	pcb_evt_s     i_evt;                  // Error pulses
	logic         i_master_active;        // Master tenure
	logic         i_gnt_n;                // Grant pin
	logic         o_lat_stop;             // Finish transfer
	logic         o_serr_report;          // System error pulse
	logic         i_cfg_t1_valid;         // Type 1 strobe
	logic [7:0]   i_cfg_t1_bus;           // Type 1 bus number
	pcb_route_s   o_route;                // Route answer
	logic [7:0]   o_primary_bus_number;   // Stored primary bus
	int           fail_count;             // Mismatches
	int           n_tests;                // Comparisons
	int           cyc;                    // Timeout counter
	int           k;                      // Loop index
	int           cnt;                    // Latency cycle count
	// Map walk: address, value at reset, value after writing FF everywhere
	localparam logic [7:0] AD[19] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D,
		8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h05, 8'h20};
	localparam logic [7:0] RV[19] = '{8'h00, 8'h02, REV, 8'h00, 8'h07, 8'h06, 8'h00,
		8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] WV[19] = '{8'h00, 8'h02, REV, 8'h00, 8'h07, 8'h06, 8'hFF,
		8'h82, 8'h00, 8'hF0, 8'hFF, 8'hFF, 8'h00, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h00};
	// Flag expected per event, event k is struct bit 9-k
	localparam logic [7:0] F07[10] = '{8'h80, 8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h08, 8'h40};
	localparam logic [7:0] F17[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h20, 8'h10,
		8'h01, 8'h08, 8'h40};
	// Type 1 bus numbers against card bus 05, subordinate 08
	localparam logic [7:0] RB[5] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h04};
	localparam logic [2:0] RX[5] = '{3'b110, 3'b101, 3'b101, 3'b100, 3'b100};
	// Latency: setting, grant release cycle, stop window low and high (0 = never)
	localparam logic [7:0] LS[6] = '{8'h01, 8'h02, 8'h08, 8'h01, 8'h00, 8'h09};
	localparam int RA[6] = '{2, 10, 58, 30, 0, 0};
	localparam int LO[6] = '{8, 16, 64, 33, 0, 0};
	localparam int HI[6] = '{12, 20, 68, 38, 0, 0};

	// --------------------------------------------------------------
	// Instances
	// --------------------------------------------------------------
	pcb_config_header #(.SILICON_REVISION(REV)) uut (.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rd_data(o_rd_data), .i_evt(i_evt),
		.i_master_active(i_master_active), .i_gnt_n(i_gnt_n), .o_lat_stop(o_lat_stop),
		.o_serr_report(o_serr_report), .i_cfg_t1_valid(i_cfg_t1_valid),
		.i_cfg_t1_bus(i_cfg_t1_bus), .o_route(o_route),
		.o_primary_bus_number(o_primary_bus_number));
	pcb_host_model host (.i_clk_sys(i_clk_sys), .i_rd_data(o_rd_data), .o_bus(i_bus));

	// Clock generation
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// --------------------------------------------------------------
	// Checking and closing
	// --------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
			fail_count++;
		end
	endtask : chk

	// Read one byte and compare
	task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		host.rd_byte(addr, d);
		chk(d, exp, $sformatf("register %h", addr));
	endtask : rchk

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// Hang guard, far above the fewer than one thousand cycles the tests need
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			$display("MISMATCH at %0t: timeout", $time);
			fail_count++;
			end_of_test();
		end
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		i_sys_rst = 1'b1;
		i_evt = '0;
		i_master_active = 1'b0;
		i_gnt_n = 1'b0;
		i_cfg_t1_valid = 1'b0;
		i_cfg_t1_bus = 8'h00;
		fail_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (5) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		// Reset values, then FF everywhere: only writable bits may move
		for (k = 0; k < 19; k++) rchk(AD[k], RV[k]);
		for (k = 0; k < 19; k++) host.wr_byte(AD[k], 8'hFF);
		for (k = 0; k < 19; k++) rchk(AD[k], WV[k]);
		$display("test map and access kinds done");
		// Each event sets its flag; writing 0 to it keeps it, writing 1 clears
		for (k = 0; k < 10; k++) begin
			@(posedge i_clk_sys);
			i_evt <= pcb_evt_s'(10'h200 >> k);
			@(posedge i_clk_sys);
			i_evt <= '0;
			#1 chk({7'h00, o_serr_report}, (k == 9) ? 8'h01 : 8'h00, "report");
			rchk(8'h07, 8'h02 | F07[k]);
			rchk(8'h17, 8'h02 | F17[k]);
			host.wr_byte(8'h07, 8'hFF ^ F07[k]);
			host.wr_byte(8'h17, 8'hFF ^ F17[k]);
			rchk(8'h07, 8'h02 | F07[k]);
			rchk(8'h17, 8'h02 | F17[k]);
			host.wr_byte(8'h07, F07[k]);
			host.wr_byte(8'h17, F17[k]);
			rchk(8'h07, 8'h02);
			rchk(8'h17, 8'h02);
		end
		// Reporting disabled: no pulse and no flag
		host.wr_byte(8'h05, 8'h00);
		@(posedge i_clk_sys);
		i_evt <= pcb_evt_s'(10'h001);
		@(posedge i_clk_sys);
		i_evt <= '0;
		#1 chk({7'h00, o_serr_report}, 8'h00, "report off");
		rchk(8'h07, 8'h02);
		$display("test status flags done");
		// Bus numbers and Type 1 routing
		host.wr_byte(8'h18, 8'h11);
		host.wr_byte(8'h19, 8'h05);
		host.wr_byte(8'h1A, 8'h08);
		rchk(8'h19, 8'h05);
		chk(o_primary_bus_number, 8'h11, "primary bus");
		for (k = 0; k < 5; k++) begin
			@(posedge i_clk_sys);
			i_cfg_t1_valid <= 1'b1;
			i_cfg_t1_bus <= RB[k];
			@(posedge i_clk_sys);
			i_cfg_t1_valid <= 1'b0;
			i_cfg_t1_bus <= ~RB[k];
			#1 chk({5'h00, o_route}, {5'h00, RX[k]}, "route");
			@(posedge i_clk_sys);
			#1 chk({5'h00, o_route}, 8'h00, "route end");
		end
		$display("test routing done");
		// Latency: grant held until a set cycle, stop follows timer and grant
		for (k = 0; k < 6; k++) begin
			host.wr_byte(8'h0D, LS[k]);
			@(posedge i_clk_sys);
			i_master_active <= 1'b1;
			for (cnt = 0; cnt < 80 && o_lat_stop !== 1'b1; cnt++) begin
				@(posedge i_clk_sys);
				if (cnt == RA[k]) i_gnt_n <= 1'b1;
				#1;
			end
			if (LO[k] == 0) chk(8'(cnt), 8'd80, "timer off");
			else chk({7'h00, cnt >= LO[k] && cnt <= HI[k]}, 8'h01, "stop time");
			@(posedge i_clk_sys);
			i_master_active <= 1'b0;
			i_gnt_n <= 1'b0;
			@(posedge i_clk_sys);
			#1 chk({7'h00, o_lat_stop}, 8'h00, "stop release");
			repeat (6) @(posedge i_clk_sys);
		end
		$display("test latency timer done");
		// Second reset in mid-run restores settings
		@(posedge i_clk_sys);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		rchk(8'h0D, 8'h00);
		rchk(8'h1A, 8'h00);
		$display("test second reset done");
		end_of_test();
	end

endmodule : pcb_config_header_tb

// ### pcb_consts.svh
// Purpose: Offsets, field positions and fixed values of the config header slice
// Assumes: Byte-wide register port, byte offsets as in the header map
// Notes:   Definitions only; included by bare name
`ifndef PCB_CONSTS_SVH
`define PCB_CONSTS_SVH

// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define PCB_OFF_ERR_CTRL     8'h05
`define PCB_OFF_PRI_STS_LO   8'h06
`define PCB_OFF_PRI_STS_HI   8'h07
`define PCB_OFF_REVISION     8'h08
`define PCB_OFF_CLASS_PIF    8'h09
`define PCB_OFF_CLASS_SUB    8'h0A
`define PCB_OFF_CLASS_BASE   8'h0B
`define PCB_OFF_LATENCY      8'h0D
`define PCB_OFF_HDR_TYPE     8'h0E
`define PCB_OFF_BAR_B0       8'h10
`define PCB_OFF_BAR_B1       8'h11
`define PCB_OFF_BAR_B2       8'h12
`define PCB_OFF_BAR_B3       8'h13
`define PCB_OFF_SEC_STS_LO   8'h16
`define PCB_OFF_SEC_STS_HI   8'h17
`define PCB_OFF_PRI_BUSN     8'h18
`define PCB_OFF_SEC_BUSN     8'h19
`define PCB_OFF_SUB_BUSN     8'h1A

// --------------------------------------------------------------
// Status bit positions and fixed fields
// --------------------------------------------------------------
`define PCB_STS_PERR         15
`define PCB_STS_SERR         14
`define PCB_STS_MABORT       13
`define PCB_STS_TABORT_RX    12
`define PCB_STS_TABORT_SIG   11
`define PCB_STS_DPERR        8
`define PCB_STS_W1C_MASK     16'hF900
`define PCB_STS_DEVSEL_MED   16'h0200
`define PCB_STS_RESET        16'h0000

// --------------------------------------------------------------
// Fixed identity and class values
// --------------------------------------------------------------
`define PCB_CLASS_PIF        8'h00
`define PCB_CLASS_SUB        8'h07
`define PCB_CLASS_BASE       8'h06
`define PCB_HDR_TYPE         8'h82
`define PCB_BAR_LOW_BITS     12

// --------------------------------------------------------------
// Latency timer
// --------------------------------------------------------------
`define PCB_LAT_STEP_SHIFT   3
`define PCB_LAT_MAX_SETTING  8'h08
`define PCB_LAT_RESET        8'h00
`define PCB_BUSN_RESET       8'h00

`endif

// ### pcb_host_model.sv
// Purpose: Configuration host model driving the byte-wide register port
// Assumes: One-cycle strobes; read data stands in the cycle after the read strobe
// Notes:   All request signals change by non-blocking assignment after a rising edge
`timescale 1ns/1ps

module pcb_host_model
	import pcb_pkg::*;
(
	// Clock
	input  wire logic         i_clk_sys,
	// Register port, read side
	input  wire logic [7:0]   i_rd_data,
	// Register port, request side
	output pcb_bus_req_s      o_bus
);

	// --------------------------------------------------------------
	// Idle state of the port
	// --------------------------------------------------------------
	// Strobes low from time zero
	initial begin
		o_bus = '0;
	end

	// --------------------------------------------------------------
	// Bus cycles
	// --------------------------------------------------------------
	// One-cycle write; released lines show the inverse so stale values never help
	// Software programs bus numbers and settings through this cycle
	task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge i_clk_sys);
		o_bus <= '{1'b1, 1'b0, addr, data};
		@(posedge i_clk_sys);
		o_bus <= '{1'b0, 1'b0, ~addr, ~data};
	endtask : wr_byte

	// One-cycle read; data taken in the following cycle, the only one it stands
	task automatic rd_byte(input logic [7:0] addr, output logic [7:0] data);
		@(posedge i_clk_sys);
		o_bus <= '{1'b0, 1'b1, addr, 8'h00};
		@(posedge i_clk_sys);
		o_bus <= '{1'b0, 1'b0, ~addr, 8'hFF};
		#1 data = i_rd_data;
	endtask : rd_byte

endmodule : pcb_host_model

// ### pcb_pkg.sv
// Purpose: Types shared by the config header slice
// Assumes: Constants live in pcb_consts.svh
// Notes:   Carrier structs for bus, events and routing
package pcb_pkg;

	// --------------------------------------------------------------
	// Register port request
	// --------------------------------------------------------------
	typedef struct packed {
		logic       wr;       // One-cycle write strobe
		logic       rd;       // One-cycle read strobe
		logic [7:0] addr;     // Byte offset
		logic [7:0] wdata;    // Write byte
	} pcb_bus_req_s;

	// --------------------------------------------------------------
	// Error events from the bus engines, one-cycle pulses
	// --------------------------------------------------------------
	typedef struct packed {
		logic pri_perr;       // Parity error seen on primary
		logic pri_mabort;     // Master abort received on primary
		logic pri_tabort_rx;  // Target abort received on primary
		logic pri_dperr;      // Data parity error on primary
		logic sec_perr;       // Parity error seen on card bus
		logic sec_mabort;     // Master abort received on card bus
		logic sec_tabort_rx;  // Target abort received on card bus
		logic sec_dperr;      // Data parity error on card bus
		logic tabort_sig;     // Bridge signalled a target abort
		logic sys_err;        // System error wants reporting
	} pcb_evt_s;

	// --------------------------------------------------------------
	// Type 1 configuration routing answer
	// --------------------------------------------------------------
	typedef struct packed {
		logic valid;          // Decision strobe
		logic to_type0;       // Claim and convert to Type 0
		logic pass_type1;     // Forward unchanged as Type 1
	} pcb_route_s;

	// Machine of the latency timer
	typedef enum logic [1:0] {
		PCB_LAT_IDLE,
		PCB_LAT_RUN,
		PCB_LAT_DONE
	} pcb_lat_e;

endpackage : pcb_pkg
